// [hw/fpc_ctrl.sv]
// Flash program/erase control, block protection, low power.
// Assumes an APB master on pclk and array signals on pclk.
//
// Summary of operation
// - Unrelated bus traffic between steps is tolerated
// - Protection runs from start to FFFF
// - Protected target refuses high voltage enable
// - All-ones protect byte leaves array open
// - Non-FF byte locks itself and protected pages
// - Start address is 11, byte, six zeros
// - Byte 80 locks all, steps 64 bytes
// - Protect byte changes only by programming
// - High voltage level bypasses all protection
// - Wait mode turns charge pump off
// - Control bits hold through wait mode unless stop is also set
// - Stop in read mode enters standby
// - Stop during operation aborts into standby
// - Standby holds every array control inactive
// - High voltage only after select and preparation
// - Program and erase selects never both set
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  protect_boundary_byte,
    input  wire logic        high_voltage_level,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    output logic             arr_program,
    output logic             arr_erase,
    output logic             arr_mass,
    output logic             arr_pump_on,
    output logic             arr_write,
    output logic      [15:0] arr_addr,
    output logic      [7:0]  arr_data,
    output logic             arr_standby
);
    import fpc_pkg::*;

    // ------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign rd      = acc & ~pwrite;
    assign hit     = (paddr == `FPC_CTRL_OFS) ||
                     (paddr == `FPC_PROT_OFS) ||
                     (paddr == `FPC_LATCH_OFS) ||
                     (paddr == `FPC_STAT_OFS);
    // Zero-wait slave; read data was staged in setup
    assign pready  = acc;
    assign pslverr = acc & ~hit;

    // ------------------------------------------------------
    // Pin synchroniser for the high-voltage sense
    // ------------------------------------------------------
    logic hvl_s1_r;
    logic hvl_s2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hvl_s1_r <= 1'b0;
            hvl_s2_r <= 1'b0;
        end else begin
            hvl_s1_r <= high_voltage_level;
            hvl_s2_r <= hvl_s1_r;
        end
    end

    // ------------------------------------------------------
    // Protection decode
    // ------------------------------------------------------
    logic [15:0] prot_start;
    logic        prot_on;
    logic        tgt_locked;
    logic [15:0] addr_r;
    // Start is a 64-byte page in the top quarter
    assign prot_start = {`FPC_TOP_BITS, protect_boundary_byte[7:0],
                         `FPC_LOW_BITS};
    // All ones means nothing locked
    assign prot_on    = (protect_boundary_byte != `FPC_OPEN_BYTE);
    // Range closes at top of map; byte guards itself
    assign tgt_locked = prot_on & ~hvl_s2_r &
                        ((addr_r >= prot_start &&
                          addr_r <= `FPC_FLASH_TOP) ||
                         addr_r == `FPC_PROT_LOC);

    // ------------------------------------------------------
    // Control bits, latch and sequence
    // ------------------------------------------------------
    logic         pgm_r;
    logic         pgm_nxt;
    logic         ers_r;
    logic         ers_nxt;
    logic         mass_r;
    logic         mass_nxt;
    logic         hv_r;
    logic         hv_nxt;
    logic [15:0]  addr_nxt;
    logic [7:0]   data_r;
    logic [7:0]   data_nxt;
    logic         wstb_r;
    logic         wstb_nxt;
    fpc_seq_type  seq_r;
    fpc_seq_type  seq_nxt;
    logic         w_ctrl;
    logic         w_latch;
    logic         r_prot;
    assign w_ctrl  = wr & (paddr == `FPC_CTRL_OFS);
    assign w_latch = wr & (paddr == `FPC_LATCH_OFS);
    assign r_prot  = rd & (paddr == `FPC_PROT_OFS);

    // Next state; frozen in wait unless stop is also set, so settings survive
    always_comb begin
        pgm_nxt  = pgm_r;
        ers_nxt  = ers_r;
        mass_nxt = mass_r;
        hv_nxt   = hv_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        wstb_nxt = 1'b0;
        seq_nxt  = seq_r;
        if (stop_mode) begin
            // Abort any operation, drop to read mode
            pgm_nxt  = 1'b0;
            ers_nxt  = 1'b0;
            mass_nxt = 1'b0;
            hv_nxt   = 1'b0;
            seq_nxt  = FPC_IDLE;
        end else if (!wait_mode) begin
            if (w_ctrl) begin
                // Both selects at once is refused
                if (!(pwdata[`FPC_PGM_BIT] &&
                      pwdata[`FPC_ERASE_BIT])) begin
                    pgm_nxt = pwdata[`FPC_PGM_BIT] & ~ers_r;
                    ers_nxt = pwdata[`FPC_ERASE_BIT] & ~pgm_r;
                end
                mass_nxt = pwdata[`FPC_MASS_BIT];
                // Set only when armed and unlocked
                if (!pwdata[`FPC_HIGH_VOLTAGE_ENABLE_BIT]) begin
                    hv_nxt = 1'b0;
                end else if (seq_r == FPC_ARMED &&
                             !tgt_locked) begin
                    hv_nxt = 1'b1;
                end
            end
            // Array data write; the protect byte itself only
            // changes this way, never by a bus store
            if (w_latch) begin
                addr_nxt = pwdata[`FPC_LADDR_HI:`FPC_LADDR_LO];
                data_nxt = pwdata[7:0];
                wstb_nxt = pgm_r | ers_r;
            end
            // Unrelated traffic leaves the step alone
            case (seq_r)
                FPC_IDLE: begin
                    if (pgm_nxt || ers_nxt) begin
                        seq_nxt = FPC_SELECTED;
                    end
                end
                FPC_SELECTED: begin
                    if (r_prot) begin
                        seq_nxt = FPC_PROT_SEEN;
                    end
                end
                FPC_PROT_SEEN: begin
                    if (w_latch) begin
                        seq_nxt = FPC_ARMED;
                    end
                end
                FPC_ARMED: begin
                    seq_nxt = FPC_ARMED;
                end
                default: begin
                    seq_nxt = FPC_IDLE;
                end
            endcase
            if (!pgm_nxt && !ers_nxt && !hv_nxt) begin
                seq_nxt = FPC_IDLE;
            end
        end
    end

    // Registers; reset gives read mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pgm_r  <= 1'b0;
            ers_r  <= 1'b0;
            mass_r <= 1'b0;
            hv_r   <= 1'b0;
            addr_r <= `FPC_ADDR_RST;
            data_r <= `FPC_DATA_RST;
            wstb_r <= 1'b0;
            seq_r  <= FPC_IDLE;
        end else begin
            pgm_r  <= pgm_nxt;
            ers_r  <= ers_nxt;
            mass_r <= mass_nxt;
            hv_r   <= hv_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            wstb_r <= wstb_nxt;
            seq_r  <= seq_nxt;
        end
    end

    // ------------------------------------------------------
    // Array outputs; standby silences all the others
    // ------------------------------------------------------
    logic stby;
    assign stby        = stop_mode;
    assign arr_standby = stby;
    assign arr_program = pgm_r & ~stby;
    assign arr_erase   = ers_r & ~stby;
    assign arr_mass    = mass_r & ~stby;
    assign arr_write   = wstb_r & ~stby;
    assign arr_addr    = stby ? `FPC_ADDR_RST : addr_r;
    assign arr_data    = stby ? `FPC_DATA_RST : data_r;
    // Pump off in wait though the bits are kept unless stop
    assign arr_pump_on = hv_r & ~wait_mode & ~stby;

    // ------------------------------------------------------
    // Read data, staged in the setup phase
    // ------------------------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = rdata_r;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `FPC_CTRL_OFS:  rdata_nxt = {28'h0, hv_r, mass_r,
                                             ers_r, pgm_r};
                `FPC_PROT_OFS:  rdata_nxt = {24'h0,
                                             protect_boundary_byte};
                `FPC_LATCH_OFS: rdata_nxt = {8'h00, addr_r, data_r};
                `FPC_STAT_OFS:  rdata_nxt = {26'h0, hvl_s2_r,
                                             arr_pump_on, tgt_locked,
                                             prot_on, seq_r};
                default:        rdata_nxt = 32'h0;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign prdata = rdata_r;

    // ------------------------------------------------------
    // Assertions
    // ------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sel_exclusive: assert property (!(pgm_r && ers_r))
        else $error("program and erase both selected");
    a_hv_needs_arm: assert property (
        $rose(hv_r) |-> $past(seq_r) == FPC_ARMED)
        else $error("high voltage set without preparation");
    a_hv_locked: assert property (
        $rose(hv_r) |-> !$past(tgt_locked))
        else $error("high voltage set on locked target");
    a_open_byte: assert property (
        protect_boundary_byte == `FPC_OPEN_BYTE |-> !tgt_locked)
        else $error("open protect byte locked a target");
    a_bypass_hv: assert property (
        hvl_s2_r |-> !tgt_locked)
        else $error("high voltage level did not bypass lock");
    a_self_lock: assert property (
        prot_on && !hvl_s2_r && addr_r == `FPC_PROT_LOC
        |-> tgt_locked)
        else $error("protect byte location left open");
    a_wait_pump: assert property (
        wait_mode |-> !arr_pump_on)
        else $error("pump on during wait");
    a_wait_hold: assert property (
        wait_mode && !stop_mode |=> $stable({pgm_r, ers_r, hv_r}))
        else $error("control bits changed in wait");
    a_stop_abort: assert property (
        stop_mode |=> !pgm_r && !ers_r && !hv_r)
        else $error("stop did not abort operation");
    a_standby_quiet: assert property (
        arr_standby |-> !(arr_program || arr_erase || arr_mass ||
                          arr_write || arr_pump_on))
        else $error("array control active in standby");
    a_start_addr: assert property (
        prot_start[5:0] == 6'h00 && prot_start[15:14] == 2'h3)
        else $error("protect start malformed");

    c_program_hv: cover property ($rose(hv_r) && pgm_r);
    c_erase_hv: cover property ($rose(hv_r) && ers_r);
    c_refused: cover property (w_ctrl && pwdata[`FPC_HIGH_VOLTAGE_ENABLE_BIT] &&
                               seq_r == FPC_ARMED && tgt_locked);
    c_stop_abort: cover property (stop_mode && hv_r);
endmodule

// [hw/fpc_defs.svh]
// Offsets, field positions and reset values of the flash
// program and protect controller. Assumes a 32-bit APB bus.
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
// ----------------------------------------------------------
// Register offsets
// ----------------------------------------------------------
`define FPC_CTRL_OFS      8'h00
`define FPC_PROT_OFS      8'h04
`define FPC_LATCH_OFS     8'h08
`define FPC_STAT_OFS      8'h0C
// ----------------------------------------------------------
// Control field positions
// ----------------------------------------------------------
`define FPC_PGM_BIT       0
`define FPC_ERASE_BIT     1
`define FPC_MASS_BIT      2
`define FPC_HIGH_VOLTAGE_ENABLE_BIT      3
`define FPC_CTRL_RST      4'h0
// ----------------------------------------------------------
// Latch register fields: address [23:8], data [7:0]
// ----------------------------------------------------------
`define FPC_LADDR_HI      23
`define FPC_LADDR_LO      8
// ----------------------------------------------------------
// Protection constants
// ----------------------------------------------------------
`define FPC_OPEN_BYTE     8'hFF
`define FPC_TOP_BITS      2'h3
`define FPC_LOW_BITS      6'h00
`define FPC_PROT_LOC      16'hFF7E
`define FPC_FLASH_TOP     16'hFFFF
`define FPC_ADDR_RST      16'h0000
`define FPC_DATA_RST      8'h00
// ----------------------------------------------------------
// Software step timing in 20 MHz cycles, not enforced here
// ----------------------------------------------------------
`define FPC_SETUP_CYC     200   // 10 us before high voltage
`define FPC_SETTLE_CYC    100   // 5 us pump settle
`define FPC_BYTE_CYC      600   // 30 us per byte
`define FPC_HOLD_CYC      100   // 5 us hold after select off
`define FPC_RECOVER_CYC   20    // 1 us back to read
`define FPC_ROW_BYTES     32
`endif

// [hw/fpc_pkg.sv]
// Types shared by the flash program and protect controller.
// Assumes fpc_defs.svh supplies all numeric constants.
package fpc_pkg;
    // Preparatory sequence position
    typedef enum logic [1:0] {
        FPC_IDLE,
        FPC_SELECTED,
        FPC_PROT_SEEN,
        FPC_ARMED
    } fpc_seq_type;
endpackage

// [tb/tb.sv]
// Self-checking bench for the flash program and protect controller.
// Assumes fpc_ctrl, fpc_defs.svh and fpc_pkg compiled before it.
`timescale 1ns/1ps
`include "fpc_defs.svh"
module tb;
    import fpc_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  prot_byte;
    logic        hv_level;
    logic        wait_mode;
    logic        stop_mode;
    logic        arr_program;
    logic        arr_erase;
    logic        arr_mass;
    logic        arr_pump_on;
    logic        arr_write;
    logic [15:0] arr_addr;
    logic [7:0]  arr_data;
    logic        arr_standby;
    int          bad_count;
    int          check_count;
    logic [15:0] lfsr;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  tb_byte [6] = '{8'hFF, 8'h80, 8'h81, 8'h81, 8'hFE, 8'hFE};
    logic [15:0] tb_addr [6] = '{16'hFFFF, 16'hE000, 16'hE03F,
                                 16'hE040, 16'hFF7E, 16'hFF7F};
    logic [3:0]  sel_tab [3] = '{4'h1, 4'h2, 4'h6};

    fpc_ctrl i_fpc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .protect_boundary_byte(prot_byte),
        .high_voltage_level(hv_level), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .arr_program(arr_program),
        .arr_erase(arr_erase), .arr_mass(arr_mass),
        .arr_pump_on(arr_pump_on), .arr_write(arr_write),
        .arr_addr(arr_addr), .arr_data(arr_data),
        .arr_standby(arr_standby));

    // ----------------------------------------------------------
    // Clock, helpers
    // ----------------------------------------------------------
    // 20 MHz bus clock
    always #25 pclk = ~pclk;

    // Pseudo-random source, fixed start for repeatable runs
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Lock expected from protect byte, target and bypass pin
    function automatic logic locked(input logic [7:0] b,
                                    input logic [15:0] a, input logic v);
        return (b != `FPC_OPEN_BYTE) && !v &&
               (a >= {`FPC_TOP_BITS, b, `FPC_LOW_BITS} ||
                a == `FPC_PROT_LOC);
    endfunction

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer from the bench, never from the array it
    // programs; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Full preparatory sequence, high voltage attempt, clean exit
    task automatic run_seq(input logic [3:0] sel, input logic [7:0] b,
                           input logic [15:0] a, input logic v);
        prot_byte <= b;
        apb(1'b1, `FPC_CTRL_OFS, {28'h0, sel});
        apb(1'b0, `FPC_PROT_OFS, 32'h0);
        chk(rd, {24'h0, b});
        apb(1'b0, `FPC_STAT_OFS, 32'h0);
        chk({rd[5], rd[2:0]}, {v, b != `FPC_OPEN_BYTE, 2'h2});
        apb(1'b1, `FPC_LATCH_OFS, {8'h0, a, lfsr[7:0]});
        apb(1'b1, `FPC_CTRL_OFS, {28'h0, sel | 4'h8});
        apb(1'b0, `FPC_CTRL_OFS, 32'h0);
        chk(rd[3], !locked(b, a, v));
        chk(arr_pump_on, !locked(b, a, v));
        chk({arr_mass, arr_erase, arr_program}, {29'h0, sel[2:0]});
        apb(1'b1, `FPC_CTRL_OFS, {28'h0, rd[3:0] & 4'h8});
        apb(1'b1, `FPC_CTRL_OFS, 32'h0);
        apb(1'b0, `FPC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        pclk        = 0;
        presetn     = 0;
        psel        = 0;
        penable     = 0;
        pwrite      = 0;
        paddr       = 0;
        pwdata      = 0;
        prot_byte   = 8'hFF;
        hv_level    = 0;
        wait_mode   = 0;
        stop_mode   = 0;
        bad_count   = 0;
        check_count = 0;
        lfsr        = 16'h0025;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk({arr_program, arr_erase, arr_pump_on, arr_standby},
            32'h0);
        apb(1'b0, `FPC_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        // Interlock and premature high voltage
        apb(1'b1, `FPC_CTRL_OFS, 32'h3);
        apb(1'b0, `FPC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `FPC_CTRL_OFS, 32'h1);
        apb(1'b1, `FPC_CTRL_OFS, 32'h2);
        apb(1'b1, `FPC_CTRL_OFS, 32'h9);
        apb(1'b0, `FPC_CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `FPC_CTRL_OFS, 32'h0);
        // Boundary table, every select mode
        foreach (tb_byte[i])
            run_seq(sel_tab[i % 3], tb_byte[i], tb_addr[i], 1'b0);
        // Random bytes and targets, with and without bypass
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            hv_level <= lfsr[0];
            repeat (4) @(posedge pclk);
            run_seq(sel_tab[i % 3], lfsr[15:8] | 8'h80,
                    {3'h7, lfsr[12:0]}, lfsr[0]);
        end
        hv_level <= 1'b0;
        repeat (4) @(posedge pclk);
        // Whole row with the software waits between steps
        prot_byte <= 8'hFF;
        apb(1'b1, `FPC_CTRL_OFS, 32'h1);
        apb(1'b0, `FPC_PROT_OFS, 32'h0);
        apb(1'b1, `FPC_LATCH_OFS, 32'h00E1_0000);
        repeat (`FPC_SETUP_CYC) @(posedge pclk);
        apb(1'b1, `FPC_CTRL_OFS, 32'h9);
        repeat (`FPC_SETTLE_CYC) @(posedge pclk);
        chk(arr_pump_on, 32'h1);
        for (int j = 0; j < `FPC_ROW_BYTES; j++) begin
            lfsr = lfsr_next(lfsr);
            apb(1'b1, `FPC_LATCH_OFS, {8'h0, 16'hE100 + 16'(j), lfsr[7:0]});
            @(negedge pclk);
            chk({arr_write, arr_addr, arr_data},
                {1'b1, 16'hE100 + 16'(j), lfsr[7:0]});
            repeat (`FPC_BYTE_CYC) @(posedge pclk);
        end
        apb(1'b1, `FPC_CTRL_OFS, 32'h8);
        repeat (`FPC_HOLD_CYC) @(posedge pclk);
        apb(1'b1, `FPC_CTRL_OFS, 32'h0);
        repeat (`FPC_RECOVER_CYC) @(posedge pclk);
        apb(1'b0, `FPC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        // Wait mode: pump off, bits kept, writes ignored
        apb(1'b1, `FPC_CTRL_OFS, 32'h1);
        apb(1'b0, `FPC_PROT_OFS, 32'h0);
        apb(1'b1, `FPC_LATCH_OFS, 32'h00E1_2355);
        apb(1'b1, `FPC_CTRL_OFS, 32'h9);
        wait_mode <= 1'b1;
        apb(1'b1, `FPC_CTRL_OFS, 32'h0);
        chk({arr_pump_on, arr_program}, 32'h1);
        apb(1'b0, `FPC_CTRL_OFS, 32'h0);
        chk(rd, 32'h9);
        wait_mode <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        chk(arr_pump_on, 32'h1);
        // Stop mode: abort into standby
        @(posedge pclk);
        stop_mode <= 1'b1;
        @(negedge pclk);
        chk({arr_standby, arr_program, arr_pump_on, arr_write},
            32'h8);
        chk({arr_addr, arr_data, arr_erase, arr_mass},
            32'h0);
        @(posedge pclk);
        stop_mode <= 1'b0;
        apb(1'b0, `FPC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        stop_mode <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk(arr_standby, 32'h1);
        @(posedge pclk);
        stop_mode <= 1'b0;
        // Wait entered mid-program is left by reset
        apb(1'b1, `FPC_CTRL_OFS, 32'h1);
        apb(1'b0, `FPC_PROT_OFS, 32'h0);
        apb(1'b1, `FPC_LATCH_OFS, 32'h00E1_2355);
        apb(1'b1, `FPC_CTRL_OFS, 32'h9);
        wait_mode <= 1'b1;
        @(posedge pclk);
        presetn   <= 1'b0;
        wait_mode <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({arr_program, arr_pump_on, arr_write, arr_addr},
            32'h0);
        apb(1'b0, `FPC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        give_verdict();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(50 * 40000);
        bad_count++;
        give_verdict();
    end
endmodule
